// ---- intc_core.sv ----
// Interrupt controller with event transfer channels and AHB-Lite registers.
// Assumes the CPU takes offered services and performs one-cycle moves.
//
// Behaviour
// - Internal-code interrupt service starts 5 to 12 clocks after request.
// - Each node is software-routed to vectored interrupt or event transfer.
// - A transfer steals one cycle; no program suspension, no vector branch.
// - Transfer moves byte or word, then bumps source or destination pointer.
// - Each transfer decrements channel count, except in continuous mode.
// - Count reaching zero raises a standard interrupt at the node's vector.
// - Eight independent event transfer channels.
// - Each node has a control register: request, enable, priority.
// - Priority field selects one of sixteen levels.
// - Accepted service is preempted only by strictly higher priority or by a hardware trap.
// - Each node has its own dedicated vector location.
// - Fast inputs detect rising, falling or both edges as configured.
// - Software trap number enters service at that number's vector.
// - Software writing a request flag makes a genuine pending request.
// - Falling edge on the non-maskable pin vectors to its trap.
// - Power down proceeds only while non-maskable pin is low.
// - Hardware trap preempts anything unless a trap service is running.
// - Running trap service is not preempted by interrupts or transfers.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module intc_core
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // AHB-Lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // Request sources
  input  wire logic [intc_pkg::NSRC-1:0]    periph_req,
  input  wire logic [intc_pkg::NEXT-1:0]    ext_in,
  input  wire logic                         nmi_n,
  input  wire logic                         sw_trap_req,
  input  wire logic [6:0]                   sw_trap_num,
  input  wire logic                         power_down_instruction,
  // CPU side
  input  wire logic [3:0]                   cpu_level,
  input  wire logic                         svc_ack,
  input  wire logic                         trap_done,
  output intc_pkg::svc_s                    svc,
  output intc_pkg::move_s                   move,
  output logic                              power_down_enter,
  output logic                              irq
);
  import intc_pkg::*;

  core_s r;
  core_s n;

  // ==========================================================================
  // Helpers
  function automatic logic is_src(input logic [11:0] a);
    return a[11:8] == OFF_SRC[11:8] && 32'(a[7:2]) < NSRC;
  endfunction

  function automatic logic is_ch(input logic [11:0] a);
    return a[11:8] == OFF_CH[11:8] && 32'(a[7:4]) < NCH && a[3:2] != 2'h3;
  endfunction

  function automatic logic [8:0] vec_of(input logic [6:0] trap);
    return {trap, 2'b00};
  endfunction

  function automatic logic [31:0] rd(input core_s s, input logic [11:0] a);
    logic [31:0] d;
    src_ctrl_s   sc;
    chan_s       c;
    d  = 32'h0000_0000;
    sc = s.src[a[SRC_W+1:2]];
    c  = s.ch[a[6:4]];
    if (is_src(a)) begin
      d[SC_LVL +: 4] = sc.lvl;
      d[SC_EN]       = sc.en;
      d[SC_REQ]      = sc.req;
      d[SC_XFR]      = sc.xfer_sel;
      d[SC_CH +: 3]  = sc.chan;
    end else if (is_ch(a)) begin
      unique case (a[3:2])
        CH_CTRL: d = 32'({c.cont, c.word, c.inc_dst, c.cnt});
        CH_SRC:  d = 32'(c.src);
        default: d = 32'(c.dst);
      endcase
    end else if (a == OFF_EDGE) begin
      d = 32'(s.edge_cfg);
    end else if (a == OFF_STAT) begin
      d = 32'(s.stat);
    end else if (a == OFF_MASK) begin
      d = 32'(s.mask);
    end else if (a == OFF_STATE) begin
      d = 32'({s.trap_active, s.nmi_pend, s.sw_pend, s.st});
    end
    return d;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [NSRC-1:0]  hw_set;
    logic [NEV-1:0]   ev;
    logic             found;
    logic [SRC_W-1:0] win;
    logic [3:0]       best;
    logic             e_now;
    logic             e_old;
    logic [1:0]       cfg;
    logic [2:0]       c;
    logic [15:0]      step;
    logic [11:0]      wa;
    hw_set = periph_req;
    ev     = '0;
    found  = 1'b0;
    win    = '0;
    best   = cpu_level;
    e_now  = 1'b0;
    e_old  = 1'b0;
    cfg    = 2'h0;
    c      = 3'h0;
    step   = 16'h0001;
    wa     = r.dp_addr;
    n      = r;

    // Bus: address phase; reads answer in the data phase, zero wait
    n.hreadyout = 1'b1;
    n.hresp     = 1'b0;
    n.dp_wr     = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.dp_wr   = hwrite;
      n.dp_addr = haddr[11:0];
      if (!hwrite) begin
        n.hrdata = rd(r, haddr[11:0]);
      end
    end

    // Bus: write data phase
    if (r.dp_wr) begin
      if (is_src(wa)) begin
        // Writing the request flag pends a real request
        n.src[wa[SRC_W+1:2]] = '{chan:     hwdata[SC_CH +: 3],
                                 xfer_sel: hwdata[SC_XFR],
                                 req:      hwdata[SC_REQ],
                                 en:       hwdata[SC_EN],
                                 lvl:      hwdata[SC_LVL +: 4]};
      end else if (is_ch(wa)) begin
        unique case (wa[3:2])
          CH_CTRL: begin
            n.ch[wa[6:4]].cnt     = hwdata[CC_CNT +: 8];
            n.ch[wa[6:4]].inc_dst = hwdata[CC_INCD];
            n.ch[wa[6:4]].word    = hwdata[CC_WORD];
            n.ch[wa[6:4]].cont    = hwdata[CC_CONT];
          end
          CH_SRC:  n.ch[wa[6:4]].src = hwdata[15:0];
          default: n.ch[wa[6:4]].dst = hwdata[15:0];
        endcase
      end else if (wa == OFF_EDGE) begin
        n.edge_cfg = hwdata[2*NEXT-1:0];
      end else if (wa == OFF_STAT) begin
        n.stat = r.stat & ~hwdata[NEV-1:0];
      end else if (wa == OFF_MASK) begin
        n.mask = hwdata[NEV-1:0];
      end
    end

    // Fast external inputs
    n.ext_q = ext_in;
    for (int k = 0; k < NEXT; k++) begin
      e_now = ext_in[k];
      e_old = r.ext_q[k];
      cfg   = r.edge_cfg[2*k +: 2];
      if ((cfg[0] && e_now && !e_old) || (cfg[1] && !e_now && e_old)) begin
        hw_set[k] = 1'b1;
      end
    end

    // Non-maskable pin and software trap latches
    n.nmi_q = nmi_n;
    if (r.nmi_q && !nmi_n) begin
      n.nmi_pend = 1'b1;
      ev[EV_NMI] = 1'b1;
    end
    if (sw_trap_req) begin
      n.sw_pend = 1'b1;
      n.sw_num  = sw_trap_num;
    end

    // Power down only with the pin held low
    n.pd_enter = power_down_instruction && !nmi_n;
    if (power_down_instruction && nmi_n) begin
      ev[EV_PDR] = 1'b1;
    end

    if (trap_done) begin
      n.trap_active = 1'b0;
    end

    // Priority selection over pending enabled nodes
    for (int i = 0; i < NSRC; i++) begin
      if (r.src[i].req && r.src[i].en && r.src[i].lvl > best) begin
        found = 1'b1;
        win   = SRC_W'(i);
        best  = r.src[i].lvl;
      end
    end

    n.mv.valid = 1'b0;
    unique case (r.st)
      ST_IDLE: begin
        if (r.nmi_pend && !r.trap_active) begin
          n.nmi_pend    = 1'b0;
          n.svc.vector  = vec_of(TRAP_NMI);
          n.svc.level   = LVL_TRAP;
          n.svc.is_trap = 1'b1;
          n.st          = ST_WAIT;
          n.wait_cnt    = WAIT_CYC;
        end else if (r.sw_pend) begin
          n.sw_pend     = 1'b0;
          n.svc.vector  = vec_of(r.sw_num);
          n.svc.level   = cpu_level;
          n.svc.is_trap = 1'b0;
          n.st          = ST_WAIT;
          n.wait_cnt    = WAIT_CYC;
        end else if (found && !r.trap_active) begin
          c = r.src[win].chan;
          if (r.src[win].xfer_sel && (r.ch[c].cnt != 8'h00 || r.ch[c].cont))
          begin
            // One bus cycle stolen, no vector fetch
            n.src[win].req = 1'b0;
            n.mv.valid     = 1'b1;
            n.mv.word      = r.ch[c].word;
            n.mv.src       = r.ch[c].src;
            n.mv.dst       = r.ch[c].dst;
            step = r.ch[c].word ? 16'h0002 : 16'h0001;
            if (r.ch[c].inc_dst) begin
              n.ch[c].dst = r.ch[c].dst + step;
            end else begin
              n.ch[c].src = r.ch[c].src + step;
            end
            if (!r.ch[c].cont) begin
              n.ch[c].cnt = r.ch[c].cnt - 8'h01;
              if (r.ch[c].cnt == 8'h01) begin
                // Hand the node back to the vectored path
                n.src[win].xfer_sel = 1'b0;
                n.src[win].req      = 1'b1;
                ev[c]               = 1'b1;
              end
            end
          end else begin
            // A spent channel falls back to the node's own vector
            n.src[win].xfer_sel = 1'b0;
            n.sel_idx     = win;
            n.svc.vector  = vec_of(TRAP_SRC_BASE + 7'(win));
            n.svc.level   = r.src[win].lvl;
            n.svc.is_trap = 1'b0;
            n.st          = ST_WAIT;
            n.wait_cnt    = WAIT_CYC;
          end
        end
      end
      ST_WAIT: begin
        // Pads the path to the least response time
        if (r.wait_cnt == 3'h0) begin
          n.svc.valid = 1'b1;
          n.st        = ST_OFFER;
        end else begin
          n.wait_cnt = r.wait_cnt - 3'h1;
        end
      end
      ST_OFFER: begin
        if (svc_ack) begin
          n.svc.valid = 1'b0;
          n.st        = ST_IDLE;
          if (r.svc.is_trap) begin
            n.trap_active = 1'b1;
          end else if (r.svc.vector == vec_of(TRAP_SRC_BASE + 7'(r.sel_idx)))
          begin
            // Software trap acks leave node flags alone, except at node sel_idx's vector
            n.src[r.sel_idx].req = 1'b0;
          end
        end
      end
    endcase

    // Hardware sets land last so they win over any clear
    for (int i = 0; i < NSRC; i++) begin
      if (hw_set[i]) begin
        n.src[i].req = 1'b1;
      end
    end
    n.stat = n.stat | ev;
    n.irq  = |(n.stat & n.mask);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.nmi_q     <= 1'b1;
      r.st        <= ST_IDLE;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata           = r.hrdata;
  assign hreadyout        = r.hreadyout;
  assign hresp            = r.hresp;
  assign svc              = r.svc;
  assign move             = r.mv;
  assign power_down_enter = r.pd_enter;
  assign irq              = r.irq;

endmodule

// ---- intc_pkg.sv ----
// Package for the interrupt and event transfer controller.
// Assumes a single 100 MHz clock domain and a 32-bit AHB-Lite register bus.
package intc_pkg;

  // ==========================================================================
  // Sizes
  localparam int NSRC  = 16;              // Interrupt request nodes
  localparam int SRC_W = $clog2(NSRC);
  localparam int NCH   = 8;               // Event transfer channels
  localparam int NEXT  = 4;               // Fast external inputs, nodes 0..3
  localparam int NEV   = NCH + 2;         // Sticky event bits

  // ==========================================================================
  // Timing
  localparam int CLK_NS       = 10;
  localparam int RESP_MIN_NS  = 50;
  localparam int RESP_MAX_NS  = 120;
  localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_NS;
  // Three cycles are spent on flag capture, selection and offer
  localparam logic [2:0] WAIT_CYC = 3'(RESP_MIN_CYC - 3);

  // ==========================================================================
  // Register map, byte offsets
  localparam logic [11:0] OFF_SRC   = 12'h000;  // + 4 * node
  localparam logic [11:0] OFF_CH    = 12'h100;  // + 16 * channel
  localparam logic [11:0] OFF_EDGE  = 12'h200;
  localparam logic [11:0] OFF_STAT  = 12'h204;
  localparam logic [11:0] OFF_MASK  = 12'h208;
  localparam logic [11:0] OFF_STATE = 12'h20c;
  localparam logic [1:0]  CH_CTRL   = 2'h0;     // Word within a channel
  localparam logic [1:0]  CH_SRC    = 2'h1;
  localparam logic [1:0]  CH_DST    = 2'h2;

  // Source control fields
  localparam int SC_LVL = 0;   // [3:0]
  localparam int SC_EN  = 6;
  localparam int SC_REQ = 7;
  localparam int SC_XFR = 8;
  localparam int SC_CH  = 9;   // [11:9]
  // Channel control fields
  localparam int CC_CNT  = 0;  // [7:0]
  localparam int CC_INCD = 8;
  localparam int CC_WORD = 9;
  localparam int CC_CONT = 10;

  // Event bits: channel terminal counts, then these
  localparam int EV_NMI = NCH;
  localparam int EV_PDR = NCH + 1;

  // Edge select per fast input
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Trap numbers; vector address is trap number times four
  localparam logic [6:0] TRAP_NMI      = 7'h02;
  localparam logic [6:0] TRAP_SRC_BASE = 7'h10;
  localparam logic [3:0] LVL_TRAP      = 4'hf;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OFFER} svc_st_e;

  typedef struct packed {
    logic [2:0] chan;
    logic       xfer_sel;
    logic       req;
    logic       en;
    logic [3:0] lvl;
  } src_ctrl_s;

  typedef struct packed {
    logic        cont;
    logic        word;
    logic        inc_dst;
    logic [7:0]  cnt;
    logic [15:0] src;
    logic [15:0] dst;
  } chan_s;

  typedef struct packed {
    logic       valid;
    logic [8:0] vector;
    logic [3:0] level;
    logic       is_trap;
  } svc_s;

  typedef struct packed {
    logic        valid;
    logic        word;
    logic [15:0] src;
    logic [15:0] dst;
  } move_s;

  typedef struct packed {
    src_ctrl_s [NSRC-1:0]   src;
    chan_s     [NCH-1:0]    ch;
    logic      [2*NEXT-1:0] edge_cfg;
    logic      [NEXT-1:0]   ext_q;
    logic                   nmi_q;
    logic                   nmi_pend;
    logic                   sw_pend;
    logic      [6:0]        sw_num;
    logic                   trap_active;
    svc_st_e                st;
    logic      [2:0]        wait_cnt;
    logic      [SRC_W-1:0]  sel_idx;
    svc_s                   svc;
    move_s                  mv;
    logic                   pd_enter;
    logic      [NEV-1:0]    stat;
    logic      [NEV-1:0]    mask;
    logic                   irq;
    logic                   dp_wr;
    logic      [11:0]       dp_addr;
    logic      [31:0]       hrdata;
    logic                   hreadyout;
    logic                   hresp;
  } core_s;

endpackage

// ---- intc_core_asserts.sv ----
// Port checker for the interrupt and event transfer controller.
// Bound to intc_core; one clock domain, reset active low.
`timescale 1ns/100ps
module intc_core_asserts
  import intc_pkg::*;
(
  // Clock and reset
  input wire logic           hclk,
  input wire logic           hresetn,
  // Requests and CPU side
  input wire logic           nmi_n,
  input wire logic           sw_trap_req,
  input wire logic [6:0]     sw_trap_num,
  input wire logic           power_down_instruction,
  input wire logic [3:0]     cpu_level,
  input wire logic           svc_ack,
  input wire logic           trap_done,
  input wire intc_pkg::svc_s svc,
  input wire intc_pkg::move_s move,
  input wire logic           power_down_enter
);
  // ==========================================
  // Helper: NMI trap service in progress
  logic lock_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      lock_r <= 1'b0;
    else if (svc.valid && svc_ack && svc.is_trap && svc.vector == 9'h008)
      lock_r <= 1'b1;
    else if (trap_done)
      lock_r <= 1'b0;
  end

  // Helper: open software trap, whose offer runs at CPU level
  logic       sw_open_r;
  logic [6:0] sw_num_r;
  logic       sw_hit;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_open_r <= 1'b0;
      sw_num_r  <= 7'h00;
    end else if (sw_trap_req) begin
      sw_open_r <= 1'b1;
      sw_num_r  <= sw_trap_num;
    end else if (svc.valid && svc_ack && sw_hit) begin
      sw_open_r <= 1'b0;
    end
  end
  assign sw_hit = sw_open_r && svc.vector == {sw_num_r, 2'b00};

  // ==========================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // An offer already ahead also meets the bound
  sequence s_offer;
    ##[1:12] svc.valid;
  endsequence
  sequence s_pd_ok;
    power_down_instruction && !nmi_n;
  endsequence

  a_sw_latency: assert property (
    sw_trap_req && !svc.valid |-> s_offer) else $error("slow trap offer");
  a_nmi_latency: assert property (
    $fell(nmi_n) && !lock_r && !svc.valid |-> s_offer)
    else $error("slow nmi offer");
  a_offer_holds: assert property (
    svc.valid && !svc_ack |=> svc.valid && $stable(svc))
    else $error("offer changed before ack");
  a_ack_drops: assert property (
    svc.valid && svc_ack |=> !svc.valid) else $error("offer kept after ack");
  a_pd_enter: assert property (
    s_pd_ok |=> power_down_enter) else $error("power down not entered");
  a_pd_refused: assert property (
    power_down_instruction && nmi_n |=> !power_down_enter)
    else $error("power down with pin high");
  a_pd_cause: assert property (
    power_down_enter |-> $past(power_down_instruction) && !$past(nmi_n))
    else $error("power down without cause");
  a_node_vector: assert property (
    svc.valid && !svc.is_trap && !sw_hit
    |-> svc.vector inside {[9'h040:9'h07c]}
    && svc.vector[1:0] == 2'h0) else $error("node vector out of range");
  a_level_above: assert property (
    $rose(svc.valid) && !svc.is_trap && !sw_hit |-> svc.level > cpu_level)
    else $error("offer not above cpu level");
  a_trap_lock: assert property (
    lock_r |-> !move.valid && !($rose(svc.valid) && !svc.is_trap && !sw_hit))
    else $error("trap service preempted");
endmodule

bind intc_core intc_core_asserts u_intc_core_asserts (
  .hclk(hclk), .hresetn(hresetn), .nmi_n(nmi_n),
  .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num),
  .power_down_instruction(power_down_instruction),
  .cpu_level(cpu_level), .svc_ack(svc_ack), .trap_done(trap_done),
  .svc(svc), .move(move), .power_down_enter(power_down_enter));

// ---- cpu_model.sv ----
// CPU stand-in: accepts offers promptly or slowly, ends NMI service.
// Assumes svc from intc_core and the shared clock.
`timescale 1ns/100ps
module cpu_model
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic           hclk,
  input  wire logic           hresetn,
  // Controller side
  input  wire intc_pkg::svc_s svc,
  input  wire logic           slow,
  output logic                svc_ack,
  output logic                trap_done,
  output intc_pkg::svc_s      last,
  output logic [7:0]          n_ack
);
  logic [5:0] wait_r;
  logic [5:0] trap_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_ack <= 1'b0;
      trap_done <= 1'b0;
      last <= '0;
      n_ack <= 8'h00;
      wait_r <= 6'h00;
      trap_r <= 6'h00;
    end else begin
      svc_ack <= 1'b0;
      trap_done <= (trap_r == 6'h01);
      if (trap_r != 6'h00)
        trap_r <= trap_r - 6'h01;
      if (svc.valid && !svc_ack) begin
        wait_r <= wait_r + 6'h01;
        if (wait_r >= (slow ? 6'h06 : 6'h00)) begin
          svc_ack <= 1'b1;
          last <= svc;
          n_ack <= n_ack + 8'h01;
          wait_r <= 6'h00;
          // Trap service long enough to test the lock
          if (svc.is_trap && svc.vector == 9'h008)
            trap_r <= 6'h1e;
        end
      end
    end
  end
endmodule

// ---- interrupt_and_event_transfer_bench.sv ----
// Self-checking bench for the interrupt and event transfer controller.
// Drives AHB-Lite and request pins; cpu_model plays the CPU.
`timescale 1ns/100ps
module interrupt_and_event_transfer_bench;
  import intc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
  logic        nmi_n, sw_trap_req, pd_insn, svc_ack, trap_done;
  logic        pd_enter, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [15:0] periph_req;
  logic [3:0]  ext_in, cpu_level;
  logic [6:0]  sw_trap_num;
  logic [7:0]  n_ack;
  svc_s        svc, last;
  move_s       move;
  int          miscompares, comparisons;

  intc_core u_intc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .periph_req(periph_req),
    .ext_in(ext_in), .nmi_n(nmi_n), .sw_trap_req(sw_trap_req),
    .sw_trap_num(sw_trap_num), .power_down_instruction(pd_insn),
    .cpu_level(cpu_level), .svc_ack(svc_ack), .trap_done(trap_done),
    .svc(svc), .move(move), .power_down_enter(pd_enter), .irq(irq));
  cpu_model u_cpu_model (.hclk(hclk), .hresetn(hresetn), .svc(svc),
    .slow(slow), .svc_ack(svc_ack), .trap_done(trap_done), .last(last),
    .n_ack(n_ack));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick_until(ref logic s, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (n >= lim) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // Entered right after a rising edge
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    tick_until(hreadyout, 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    tick_until(hreadyout, 50);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, e);
    check(32'(hresp), 32'h0);
  endtask
  task automatic expect_svc(input logic [8:0] vec);
    int n;
    logic [7:0] n0;
    n0 = n_ack;
    n = 0;
    while (n_ack === n0 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 60) begin
      miscompares++;
      wrap_up();
    end
    check({23'h0, last.vector}, {23'h0, vec});
  endtask
  task automatic no_svc;
    logic [7:0] n0;
    n0 = n_ack;
    repeat (20) @(posedge hclk);
    check({24'h0, n_ack}, {24'h0, n0});
  endtask
  task automatic node9_move;
    int n;
    n = 0;
    periph_req <= 16'h0200;
    @(posedge hclk);
    periph_req <= 16'h0;
    do begin
      @(posedge hclk);
      n++;
    end while (move.valid !== 1'b1 && n < 10);
    if (n >= 10) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // ==========================================
  // Sequence
  initial begin
    logic [11:0] b;
    logic [31:0] inc;
    int n;
    {hsel, hwrite, slow, sw_trap_req, pd_insn} = '0;
    {haddr, hwdata, htrans, periph_req, ext_in, cpu_level} = '0;
    sw_trap_num = 7'h00;
    nmi_n = 1'b1;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(12'h000, 32'h0);
    rdc(12'h300, 32'h0);
    for (int l = 0; l < 16; l++) begin
      wr(12'h020, 32'h40 | 32'(l));
      rdc(12'h020, 32'h40 | 32'(l));
    end
    wr(12'h020, 32'h0);
    wr(12'h00c, 32'h45);
    periph_req <= 16'h0008;
    n = 0;
    do begin
      @(posedge hclk);
      periph_req <= 16'h0;
      n++;
    end while (svc.valid !== 1'b1 && n < 30);
    check(32'(n >= 6 && n <= 13), 32'h1);
    expect_svc(9'h04c);
    rdc(12'h00c, 32'h45);
    slow <= 1'b1;
    wr(12'h014, 32'hc2);
    expect_svc(9'h054);
    slow <= 1'b0;
    cpu_level <= 4'hf;
    wr(12'h02c, 32'hc8);
    wr(12'h028, 32'hc8);
    wr(12'h018, 32'hc3);
    no_svc();
    cpu_level <= 4'h7;
    expect_svc(9'h068);
    expect_svc(9'h06c);
    no_svc();
    cpu_level <= 4'h0;
    expect_svc(9'h058);
    for (int c = 0; c < 8; c++) begin
      b = 12'h100 + 12'(16 * c);
      inc = c[1] ? 32'h2 : 32'h1;
      wr(b, 32'({c[1:0], 8'h01}));
      wr(b + 12'h4, 32'h1000);
      wr(b + 12'h8, 32'h2000);
      wr(12'h024, 32'(c << 9) | 32'h144);
      node9_move();
      check({move.src, move.dst}, 32'h10002000);
      check(32'(move.word), 32'(c[1]));
      check(32'(svc.valid), 32'h0);
      expect_svc(9'h064);
      rdc(b + 12'h4, 32'h1000 + (c[0] ? 32'h0 : inc));
      rdc(b + 12'h8, 32'h2000 + (c[0] ? inc : 32'h0));
      rdc(b, 32'({c[1:0], 8'h00}));
    end
    rdc(12'h204, 32'h0ff);
    check(32'(irq), 32'h0);
    wr(12'h208, 32'h001);
    repeat (2) @(posedge hclk);
    check(32'(irq), 32'h1);
    wr(12'h204, 32'h0ff);
    repeat (2) @(posedge hclk);
    check(32'(irq), 32'h0);
    rdc(12'h204, 32'h0);
    wr(12'h100, 32'h403);
    wr(12'h024, 32'h144);
    node9_move();
    rdc(12'h100, 32'h403);
    wr(12'h024, 32'h0);
    wr(12'h200, 32'h39);
    for (int i = 0; i < 3; i++) begin
      wr(12'(4 * i), 32'h41);
      ext_in[i] <= 1'b1;
      if (i != 1)
        expect_svc(9'h040 + 9'(4 * i));
      else
        no_svc();
      ext_in[i] <= 1'b0;
      if (i != 0)
        expect_svc(9'h040 + 9'(4 * i));
      else
        no_svc();
    end
    sw_trap_num <= 7'h21;
    sw_trap_req <= 1'b1;
    @(posedge hclk);
    sw_trap_req <= 1'b0;
    expect_svc(9'h084);
    nmi_n <= 1'b0;
    expect_svc(9'h008);
    check(32'(last.is_trap), 32'h1);
    wr(12'h014, 32'hc2);
    no_svc();
    expect_svc(9'h054);
    pd_insn <= 1'b1;
    @(posedge hclk);
    pd_insn <= 1'b0;
    @(posedge hclk);
    check(32'(pd_enter), 32'h1);
    rdc(12'h204, 32'h100);
    nmi_n <= 1'b1;
    pd_insn <= 1'b1;
    @(posedge hclk);
    pd_insn <= 1'b0;
    @(posedge hclk);
    check(32'(pd_enter), 32'h0);
    rdc(12'h204, 32'h300);
    wrap_up();
  end
endmodule
